// *** lrf_checker.sv ***
/* Port checker for the receive buffer and identifier filter.
   Assumes one core clock and a synchronous active-high reset. */
module lrf_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire lrf_pkg::lrf_req_t regReq,
  input wire logic [31:0] regRdata,
  // Engine side
  input wire logic frameStart,
  input wire lrf_pkg::lrf_hdr_t hdrIn,
  input wire lrf_pkg::lrf_byte_t rxByteIn,
  // Status
  input wire logic receiveReadyFlag,
  input wire logic linMode,
  input wire logic identIrq
);
  import lrf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Read data only in the cycle after a read
  chk_rdata_idle: assert property (!$past(regReq.rd) |-> regRdata == WORD_ZERO)
    else $error("read data not zero outside a read");
  chk_mask_rsvd: assert property ($past(regReq.rd && regReq.addr == OFS_MASKS) |->
    regRdata[31:24] == 8'h00 && regRdata[15:8] == 8'h00)
    else $error("mask reserved bytes not zero");
  chk_ready_set: assert property (frameStart ##1 (rxByteIn.valid && !frameStart) |=>
    receiveReadyFlag) else $error("first byte did not set ready");
  chk_ready_clear: assert property (regReq.rd && regReq.addr == OFS_RESP_LO &&
    !rxByteIn.valid |=> !receiveReadyFlag) else $error("low word read kept ready");
  chk_ready_hold: assert property (receiveReadyFlag && !regReq.rd |=> receiveReadyFlag)
    else $error("ready dropped without a read");
  chk_irq_cause: assert property ($rose(identIrq) |->
    $past(hdrIn.valid && linMode && !hdrIn.parityErr) ||
    $past(regReq.wr && regReq.addr == OFS_IRQ_EN)) else $error("interrupt without cause");
  chk_irq_hold: assert property (identIrq && !regReq.wr |=> identIrq)
    else $error("interrupt dropped without a write");
  chk_nonlin_quiet: assert property (hdrIn.valid && !linMode && !identIrq &&
    !regReq.wr |=> !identIrq) else $error("match outside lin mode");
  chk_parity_quiet: assert property (hdrIn.valid && hdrIn.parityErr && !identIrq &&
    !regReq.wr |=> !identIrq) else $error("match on parity error");
  chk_mode_write: assert property (regReq.wr && regReq.addr == OFS_CTRL |=>
    linMode == $past(regReq.wdata[LIN_MODE_BIT])) else $error("mode write lost");
endmodule : lrf_checker

bind lrf_rx_buffer_filter lrf_checker i_lrf_checker (.core_clk(core_clk), .rst(rst),
  .regReq(regReq), .regRdata(regRdata), .frameStart(frameStart), .hdrIn(hdrIn),
  .rxByteIn(rxByteIn), .receiveReadyFlag(receiveReadyFlag), .linMode(linMode),
  .identIrq(identIrq));

// *** lrf_engine_model.sv ***
/* Protocol engine stand-in giving frame starts, headers and bytes.
   Assumes the block samples these pulses on core_clk rising edges. */
module lrf_engine_model (
  // Clock
  input wire logic core_clk,
  // Engine outputs
  output logic frameStart,
  output lrf_pkg::lrf_hdr_t hdrIn,
  output lrf_pkg::lrf_byte_t rxByteIn
);
  import lrf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    frameStart = 1'b0;
    hdrIn = '0;
    rxByteIn = '0;
  end
  // One header pulse; released lines show inverted values
  task automatic sendHdr(input logic [7:0] id, input logic perr);
    @(posedge core_clk);
    hdrIn <= '{ident: id, parityErr: perr, valid: 1'b1};
    @(posedge core_clk);
    hdrIn <= '{ident: ~id, parityErr: ~perr, valid: 1'b0};
  endtask : sendHdr
  // Frame start, then n back-to-back bytes counting up from b0
  task automatic sendFrame(input int n, input logic [7:0] b0);
    @(posedge core_clk);
    frameStart <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      frameStart <= 1'b0;
      rxByteIn <= '{data: b0 + 8'(i), valid: 1'b1};
    end
    @(posedge core_clk);
    rxByteIn <= '{data: ~rxByteIn.data, valid: 1'b0};
  endtask : sendFrame
endmodule : lrf_engine_model

// *** lrf_pkg.sv ***
/*
  Shared constants and carrier types for the LIN receive buffer and
  identifier filter block. Assumes one core clock and a plain register port.
*/
package lrf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_RESP_LO = 8'h00;
  localparam logic [7:0] OFS_RESP_HI = 8'h04;
  localparam logic [7:0] OFS_MASKS = 8'h08;
  localparam logic [7:0] OFS_IDENT = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;

  // Field positions
  localparam int RX_MASK_LSB = 16;
  localparam int TX_MASK_LSB = 0;
  localparam int CAPT_LSB = 16;
  localparam int TASK_LSB = 8;
  localparam int LIN_MODE_BIT = 0;
  localparam int ST_IDENT_RECEIVE_MATCH_FLAG = 0;
  localparam int ST_IDENT_TRANSMIT_MATCH_FLAG = 1;
  localparam int ST_RX_RDY = 2;

  // Geometry and reset values
  localparam int SLOTS = 8;
  localparam int SLOTS_PER_WORD = 4;
  localparam int EVT_BITS = 2;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lrf_req_t;

  // Header identifier from the protocol engine
  typedef struct packed {
    logic [7:0] ident;
    logic parityErr;
    logic valid;
  } lrf_hdr_t;

  // Response byte from the receive shift path
  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } lrf_byte_t;
endpackage : lrf_pkg

// *** lrf_rx_buffer_filter.sv ***
/*
  Receive response buffers, identifier masks, identifier match flags,
  captured identifier and identifier interrupt of a LIN controller.
  Eight response slots are packed into two read-only words, slot zero in
  the top byte of the low word. Two identifier masks decide a receive
  match and a transmit match against the slave task identifier. Each match
  sets a sticky status bit that is cleared by writing a one to it, and an
  enable register gates both bits onto one level interrupt.
  Assumes the protocol engine runs on core_clk and gives one-cycle pulses
  for frame start, received header identifiers and received data bytes.
  Assumes the register master never raises read and write together and
  takes read data only in the cycle after the read strobe.
  Assumes the engine has already checked identifier parity and flags it
  beside the identifier in the same cycle as the valid pulse.
*/

// Functional notes
// - Each of the first eight data bytes of a frame goes to slot indexed by bytes received so far.
// - Frame byte x lands in slot x-1; slots packed high byte first.
// - Reading the low response word clears the receive-ready flag.
// - Every buffer slot is read-only, eight bits, reset to zero.
// - Identifier bits with mask zero are compared; mask one bits ignored.
// - Receive-mask match sets receive match flag, interrupt if enabled.
// - Transmit-mask match sets transmit match flag, interrupt if enabled.
// - Masks and matching act only in LIN mode.
// - Mask register reserved bytes read zero and ignore writes.
// - Captured identifier updates only without parity error and on a match.
// - Incoming identifier is compared against the slave task identifier.
module lrf_rx_buffer_filter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire lrf_pkg::lrf_req_t regReq,
  output logic [31:0] regRdata,
  // Protocol engine side
  input wire logic frameStart,
  input wire lrf_pkg::lrf_hdr_t hdrIn,
  input wire lrf_pkg::lrf_byte_t rxByteIn,
  // Status outputs
  output logic receiveReadyFlag,
  output logic linMode,
  output logic identIrq
);
  import lrf_pkg::*;

  // Buffer state
  // Byte count runs to eight and then saturates, so the
  // ninth and later bytes of a long frame are dropped silently
  logic [7:0] respSlot_r [SLOTS];
  logic [7:0] respSlot_nxt [SLOTS];
  logic [3:0] byteCount_r;
  logic [3:0] byteCount_nxt;
  logic rxReady_r;
  logic rxReady_nxt;

  // Filter state
  // Masks and task identifier are software settings;
  // the captured identifier is written only by the engine side
  logic [7:0] receiveIdentFilter_r;
  logic [7:0] receiveIdentFilter_nxt;
  logic [7:0] transmitIdentFilter_r;
  logic [7:0] transmitIdentFilter_nxt;
  logic [7:0] slaveTaskIdent_r;
  logic [7:0] slaveTaskIdent_nxt;
  logic [7:0] capturedIdent_r;
  logic [7:0] capturedIdent_nxt;
  logic linMode_r;
  logic linMode_nxt;

  // Interrupt state
  // Bit zero is the receive match, bit one the transmit match
  logic [EVT_BITS-1:0] evtStatus_r;
  logic [EVT_BITS-1:0] evtStatus_nxt;
  logic [EVT_BITS-1:0] evtEnable_r;
  logic [EVT_BITS-1:0] evtEnable_nxt;
  logic [31:0] rdData_r;
  logic [31:0] rdData_nxt;

  // Match decode
  logic [7:0] identDiff;
  logic rxMatch;
  logic txMatch;
  logic hdrAccept;
  logic [EVT_BITS-1:0] evtSet;
  logic [31:0] respLoWord;
  logic [31:0] respHiWord;

  // Identifier compare
  // A one in the difference marks a bit where the header
  // identifier and the task identifier disagree; the masks then
  // decide which of those disagreements count against a match.
  // Both matches share one difference, so a header may raise
  // a receive match and a transmit match in the same cycle.
  // compare against slave task identifier
  assign identDiff = hdrIn.ident ^ slaveTaskIdent_r;
  assign rxMatch = (identDiff & ~receiveIdentFilter_r) == 8'h00;
  assign txMatch = (identDiff & ~transmitIdentFilter_r) == 8'h00;
  // A header with a parity error is treated as if it never came,
  // which keeps a corrupted identifier out of flags and capture.
  // Outside LIN mode the masks have no effect at all.
  // only in LIN mode
  assign hdrAccept = hdrIn.valid & linMode_r & ~hdrIn.parityErr;
  assign evtSet[ST_IDENT_RECEIVE_MATCH_FLAG] = hdrAccept & rxMatch;
  assign evtSet[ST_IDENT_TRANSMIT_MATCH_FLAG] = hdrAccept & txMatch;

  // Word packing
  // Slot zero sits in bits 31-24 so that frame byte one is the
  // most significant byte software sees in the low word.
  // slot packing, lowest slot in the top byte
  always_comb begin
    respLoWord = WORD_ZERO;
    respHiWord = WORD_ZERO;
    for (int i = 0; i < SLOTS_PER_WORD; i++) begin
      respLoWord[31-8*i -: 8] = respSlot_r[i];
      respHiWord[31-8*i -: 8] = respSlot_r[i+SLOTS_PER_WORD];
    end
  end

  // Buffer next state
  // A frame start only rewinds the byte count; it wins over a byte
  // in the same cycle, so that byte is dropped rather than stored
  // in a slot of the old frame. The ready flag follows each stored
  // byte, and a stored byte beats a read clear in the same cycle
  // so that software never loses sight of fresh data.
  always_comb begin
    for (int i = 0; i < SLOTS; i++) begin
      respSlot_nxt[i] = respSlot_r[i];
    end
    byteCount_nxt = byteCount_r;
    rxReady_nxt = rxReady_r;
    // read of slot zero clears ready
    if (regReq.rd && regReq.addr == OFS_RESP_LO) begin
      rxReady_nxt = 1'b0;
    end
    if (frameStart) begin
      byteCount_nxt = 4'h0;
    end else if (rxByteIn.valid && byteCount_r < 4'(SLOTS)) begin
      respSlot_nxt[byteCount_r[2:0]] = rxByteIn.data;
      byteCount_nxt = byteCount_r + 4'h1;
      // Set wins over the read clear
      rxReady_nxt = 1'b1;
    end
  end

  // Buffer registers
  // Nothing on the register port writes a slot; reset clears all.
  // slots change only by received data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < SLOTS; i++) begin
        respSlot_r[i] <= BYTE_RST;
      end
      byteCount_r <= 4'h0;
      rxReady_r <= 1'b0;
    end else begin
      respSlot_r <= respSlot_nxt;
      byteCount_r <= byteCount_nxt;
      rxReady_r <= rxReady_nxt;
    end
  end

  // Configuration and captured identifier next state
  // Only the mask bytes, the task byte and the mode bit are stored; the reserved
  // bytes of a write fall away. The capture happens in the cycle
  // of an accepted header that matched under either mask.
  always_comb begin
    receiveIdentFilter_nxt = receiveIdentFilter_r;
    transmitIdentFilter_nxt = transmitIdentFilter_r;
    slaveTaskIdent_nxt = slaveTaskIdent_r;
    capturedIdent_nxt = capturedIdent_r;
    linMode_nxt = linMode_r;
    if (regReq.wr) begin
      unique case (regReq.addr)
        OFS_MASKS: begin
          receiveIdentFilter_nxt = regReq.wdata[RX_MASK_LSB +: 8];
          transmitIdentFilter_nxt = regReq.wdata[TX_MASK_LSB +: 8];
        end
        OFS_IDENT: begin
          slaveTaskIdent_nxt = regReq.wdata[TASK_LSB +: 8];
        end
        OFS_CTRL: begin
          linMode_nxt = regReq.wdata[LIN_MODE_BIT];
        end
        default: begin
        end
      endcase
    end
    // capture on clean header with a match
    if (hdrAccept && (rxMatch || txMatch)) begin
      capturedIdent_nxt = hdrIn.ident;
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      receiveIdentFilter_r <= BYTE_RST;
      transmitIdentFilter_r <= BYTE_RST;
      slaveTaskIdent_r <= BYTE_RST;
      capturedIdent_r <= BYTE_RST;
      linMode_r <= 1'b0;
    end else begin
      receiveIdentFilter_r <= receiveIdentFilter_nxt;
      transmitIdentFilter_r <= transmitIdentFilter_nxt;
      slaveTaskIdent_r <= slaveTaskIdent_nxt;
      capturedIdent_r <= capturedIdent_nxt;
      linMode_r <= linMode_nxt;
    end
  end

  // Interrupt next state, write one to clear, set wins
  // The set is ORed in after the clear, so a match that arrives
  // in the cycle of a clearing write is never lost.
  always_comb begin
    evtStatus_nxt = evtStatus_r;
    evtEnable_nxt = evtEnable_r;
    if (regReq.wr && regReq.addr == OFS_STATUS) begin
      evtStatus_nxt = evtStatus_r & ~regReq.wdata[EVT_BITS-1:0];
    end
    if (regReq.wr && regReq.addr == OFS_IRQ_EN) begin
      evtEnable_nxt = regReq.wdata[EVT_BITS-1:0];
    end
    evtStatus_nxt = evtStatus_nxt | evtSet;
  end

  // Interrupt registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      evtStatus_r <= '0;
      evtEnable_r <= '0;
    end else begin
      evtStatus_r <= evtStatus_nxt;
      evtEnable_r <= evtEnable_nxt;
    end
  end

  // Read data mux, answered in the next cycle
  // Read data are zero in every cycle without a read, so the
  // register output never shows stale contents of an old read.
  // Unmapped offsets and reserved bytes read zero as well.
  always_comb begin
    rdData_nxt = WORD_ZERO;
    if (regReq.rd) begin
      unique case (regReq.addr)
        OFS_RESP_LO: rdData_nxt = respLoWord;
        OFS_RESP_HI: rdData_nxt = respHiWord;
        OFS_MASKS: begin
          rdData_nxt[RX_MASK_LSB +: 8] = receiveIdentFilter_r;
          rdData_nxt[TX_MASK_LSB +: 8] = transmitIdentFilter_r;
        end
        OFS_IDENT: begin
          rdData_nxt[CAPT_LSB +: 8] = capturedIdent_r;
          rdData_nxt[TASK_LSB +: 8] = slaveTaskIdent_r;
        end
        OFS_CTRL: rdData_nxt[LIN_MODE_BIT] = linMode_r;
        OFS_STATUS: begin
          rdData_nxt[EVT_BITS-1:0] = evtStatus_r;
          rdData_nxt[ST_RX_RDY] = rxReady_r;
        end
        OFS_IRQ_EN: rdData_nxt[EVT_BITS-1:0] = evtEnable_r;
        default: rdData_nxt = WORD_ZERO;
      endcase
    end
  end

  // Read data register
  // One register stage keeps the read data off long paths
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdData_r <= WORD_ZERO;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  // Outputs
  // All status outputs come straight from registers; only the
  // interrupt is a gate of two registers, so it cannot glitch
  // on engine inputs.
  assign regRdata = rdData_r;
  assign receiveReadyFlag = rxReady_r;
  assign linMode = linMode_r;
  assign identIrq = |(evtStatus_r & evtEnable_r);
endmodule : lrf_rx_buffer_filter

// *** lrf_rx_buffer_filter_tb.sv ***
/* Self-checking bench for the receive buffer and identifier filter.
   Assumes the engine model and the bound checker are compiled first. */
module lrf_rx_buffer_filter_tb;
  import lrf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic lin;
    logic [7:0] rxM, txM, tsk, id;
    logic [1:0] en, st;
  } lrf_row_t;
  // Mode, masks, task ident, header ident, enables, expected flags
  lrf_row_t rows [6] = '{{1'b1, 8'h00, 8'h00, 8'h15, 8'h15, 2'h3, 2'h3},
    {1'b1, 8'h00, 8'hff, 8'h15, 8'h14, 2'h3, 2'h2}, {1'b1, 8'h01, 8'h00, 8'h15, 8'h14, 2'h2, 2'h1},
    {1'b1, 8'hf0, 8'h0f, 8'h15, 8'h25, 2'h1, 2'h1}, {1'b1, 8'h00, 8'h00, 8'h15, 8'h16, 2'h3, 2'h0},
    {1'b0, 8'h00, 8'h00, 8'h15, 8'h15, 2'h3, 2'h0}};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  lrf_req_t regReq = '0;
  logic [31:0] regRdata;
  logic frameStart, receiveReadyFlag, linMode, identIrq;
  lrf_hdr_t hdrIn;
  lrf_byte_t rxByteIn;
  lrf_row_t r;
  logic [7:0] capt = 8'h00;
  int nErrors = 0;
  int testsRun = 0;
  int cycles = 0;
  always #5 core_clk = ~core_clk;
  lrf_rx_buffer_filter i_lrf_rx_buffer_filter (.core_clk(core_clk), .rst(rst),
    .regReq(regReq), .regRdata(regRdata), .frameStart(frameStart), .hdrIn(hdrIn),
    .rxByteIn(rxByteIn), .receiveReadyFlag(receiveReadyFlag), .linMode(linMode),
    .identIrq(identIrq));
  lrf_engine_model i_lrf_engine_model (.core_clk(core_clk), .frameStart(frameStart),
    .hdrIn(hdrIn), .rxByteIn(rxByteIn));
  task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmpWord
  task automatic cmpBit(input logic got, input logic exp);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmpBit
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    regReq.wr <= 1'b0;
  endtask : wrReg
  task automatic rdReg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    regReq <= '{addr: a, wdata: WORD_ZERO, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    regReq.rd <= 1'b0;
    #1 cmpWord(regRdata, exp);
  endtask : rdReg
  task automatic testDone;
    $display("errors %0d compares %0d", nErrors, testsRun);
    if (nErrors == 0 && testsRun > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : testDone
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      nErrors++;
      testDone();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a < 32; a += 4) rdReg(8'(a), WORD_ZERO);
    foreach (rows[i]) begin
      r = rows[i];
      wrReg(OFS_CTRL, {31'h0, r.lin});
      #1 cmpBit(linMode, r.lin);
      wrReg(OFS_MASKS, {8'hff, r.rxM, 8'hff, r.txM});
      wrReg(OFS_IDENT, {16'h0, r.tsk, 8'h00});
      wrReg(OFS_IRQ_EN, {30'h0, r.en});
      wrReg(OFS_STATUS, 32'h3);
      i_lrf_engine_model.sendHdr(r.id, 1'b0);
      #1 cmpBit(identIrq, |(r.st & r.en));
      if (r.st != 2'h0) capt = r.id;
      rdReg(OFS_STATUS, {30'h0, r.st});
      rdReg(OFS_MASKS, {8'h00, r.rxM, 8'h00, r.txM});
      rdReg(OFS_IDENT, {8'h00, capt, r.tsk, 8'h00});
    end
    wrReg(OFS_CTRL, 32'h1);
    i_lrf_engine_model.sendHdr(8'h15, 1'b1);
    rdReg(OFS_STATUS, WORD_ZERO);
    rdReg(OFS_IDENT, {8'h00, capt, 8'h15, 8'h00});
    i_lrf_engine_model.sendFrame(9, 8'h10);
    #1 cmpBit(receiveReadyFlag, 1'b1);
    rdReg(OFS_RESP_HI, 32'h14151617);
    rdReg(OFS_RESP_LO, 32'h10111213);
    cmpBit(receiveReadyFlag, 1'b0);
    i_lrf_engine_model.sendFrame(3, 8'ha0);
    wrReg(OFS_RESP_LO, 32'hffffffff);
    wrReg(OFS_RESP_HI, 32'hffffffff);
    rdReg(OFS_RESP_LO, 32'ha0a1a213);
    rdReg(OFS_RESP_HI, 32'h14151617);
    // Second reset in mid-run
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    rdReg(OFS_RESP_LO, WORD_ZERO);
    testDone();
  end
endmodule : lrf_rx_buffer_filter_tb
